/* core/gst_timer.sv */
// Purpose: Gated 16-bit incrementing timer with APB registers.
// Assumes: Single clock pclk at 200 MHz; pins pass a three-flop filter.
// Notes: Count, capture and compare share one 16-bit time base.
// How it works
// - Gating restricts counting only when enabled.
// - Gated: count only when gate equals polarity, or while the toggle flop is set in toggle mode.
// - Two-bit select picks pin, aux, comparators.
// - Aux timer wrap pulse feeds gate.
// - Comparator gate optionally latched on count tick.
// - Toggle flop inverts each time the gate starts to equal polarity.
// - Toggle flop held clear when mode off.
// - Arm after single-pulse; count starts next edge.
// - Arm clears at pulse trailing edge.
// - Disarmed: gate events do not count.
// - Toggle plus single-pulse counts one cycle.
// - Gate level status always readable.
// - Gate level fall sets event flag, irq.
// - Event flag works with gating disabled.
// - Count wraps to zero, sets overflow.
// - Overflow irq needs on and enables.
// - Sleep counts async external only; wakes.
// - Count is capture and compare base.
// - Auto clear zeroes count, no overflow.
// - Count write beats auto clear.
// - Counter off unless on bit set.
// - Clock select: instr, sys, ext, lfosc.
// - Prescale 1/2/4/8; count write resets.
`include "gst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gst_timer
  import gst_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Gate and clock sources
  input wire logic gate_input_pin,
  input wire logic aux_timer_wrap,
  input wire logic comparator_one_gate_out,
  input wire logic comparator_two_gate_out,
  input wire logic cmp_one_sync_sel,
  input wire logic cmp_two_sync_sel,
  input wire logic external_count_clock_pin,
  input wire logic low_freq_internal_osc,
  // System and capture/compare
  input wire logic sleep_mode,
  input wire logic capture_event,
  output logic compare_event,
  output logic [15:0] count_value,
  output logic irq_req,
  output logic wake_req,
  output logic irq_vector_req
);

  gst_state_t s;
  gst_state_t d;

  logic acc;
  logic wr;
  logic mapped;
  logic cnt_wr_lo;
  logic cnt_wr_hi;
  logic raw_tick;
  logic pre_done;
  logic inc;
  logic acl;
  logic gate_src;
  logic gpol;
  logic gt;
  logic gsp;
  logic cnt_en;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = (paddr == `GST_OFF_CTRL) || (paddr == `GST_OFF_GATE) ||
                  (paddr == `GST_OFF_COUNT) || (paddr == `GST_OFF_CAPCMP) ||
                  (paddr == `GST_OFF_FLAGS) || (paddr == `GST_OFF_IRQEN);
  assign cnt_wr_lo = wr && (paddr == `GST_OFF_COUNT) && pstrb[0];
  assign cnt_wr_hi = wr && (paddr == `GST_OFF_COUNT) && pstrb[1];

  always_comb begin
    logic [2:0] mask;
    logic [15:0] nxt;
    mask = `GST_PS_M1;
    nxt = s.count;
    raw_tick = 1'b0;
    gate_src = 1'b0;
    d = s;
    // Three-flop filter: a level changes once flops two and three agree.
    d.s1 = {low_freq_internal_osc, external_count_clock_pin,
            comparator_two_gate_out, comparator_one_gate_out,
            gate_input_pin};
    d.s2 = s.s1;
    d.s3 = s.s2;
    d.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 ^ s.s3));
    d.clk_prev = {s.lvl[`GST_IN_LFO], s.lvl[`GST_IN_EXT]};
    d.div4 = s.div4 + 2'h1;
    unique case (s.cs)
      GST_CS_INSTR: raw_tick = (s.div4 == `GST_DIV4_LAST);
      GST_CS_SYS: raw_tick = 1'b1;
      GST_CS_EXT: raw_tick = s.lvl[`GST_IN_EXT] && !s.clk_prev[0];
      GST_CS_LFO: raw_tick = s.lvl[`GST_IN_LFO] && !s.clk_prev[1];
    endcase
    // Only the unsynchronised external counter keeps running in sleep.
    if (sleep_mode && !(s.cs == GST_CS_EXT && s.sbyp)) begin
      raw_tick = 1'b0;
    end
    unique case (s.ps)
      2'h0: mask = `GST_PS_M1;
      2'h1: mask = `GST_PS_M2;
      2'h2: mask = `GST_PS_M4;
      2'h3: mask = `GST_PS_M8;
    endcase
    pre_done = raw_tick && s.on && (s.pre == mask);
    if (cnt_wr_lo || cnt_wr_hi) begin
      d.pre = `GST_PRE_ZERO;
    end else if (raw_tick && s.on) begin
      d.pre = pre_done ? `GST_PRE_ZERO : s.pre + 3'h1;
    end
    // Comparator levels are resampled on every count tick; the sync selects choose them.
    if (pre_done) begin
      d.cmp_tb = {s.lvl[`GST_IN_CMP2], s.lvl[`GST_IN_CMP1]};
    end
    unique case (s.gss)
      GST_GS_PIN: gate_src = s.lvl[`GST_IN_PIN];
      GST_GS_AUX: gate_src = aux_timer_wrap;
      GST_GS_CMP1: gate_src = cmp_one_sync_sel ? s.cmp_tb[0]
                                               : s.lvl[`GST_IN_CMP1];
      GST_GS_CMP2: gate_src = cmp_two_sync_sel ? s.cmp_tb[1]
                                               : s.lvl[`GST_IN_CMP2];
    endcase
    gpol = (gate_src == s.pol);
    d.gpol_prev = gpol;
    if (!s.tm) begin
      d.tog = 1'b0;
    end else if (gpol && !s.gpol_prev) begin
      d.tog = !s.tog;
    end
    gt = s.tm ? s.tog : gpol;
    d.gt_prev = gt;
    // The run latch opens only on an edge seen while armed.
    if (!s.arm) begin
      d.sp_run = 1'b0;
    end else if (gt && !s.gt_prev) begin
      d.sp_run = 1'b1;
    end
    gsp = s.spm ? (gt && s.sp_run) : gt;
    d.gval = gsp;
    cnt_en = s.on && (!s.ge || s.gval);
    inc = pre_done && cnt_en;
    acl = s.acl_en && s.cmp_evt;
    if (inc) begin
      nxt = s.count + 16'h0001;
    end
    if (acl) begin
      nxt = `GST_CNT_ZERO;
    end
    if (cnt_wr_lo) begin
      nxt[7:0] = pwdata[7:0];
    end
    if (cnt_wr_hi) begin
      nxt[15:8] = pwdata[15:8];
    end
    d.count = nxt;
    d.match_prev = s.cmp_en && (s.count == s.capcmp);
    d.cmp_evt = s.cmp_en && (s.count == s.capcmp) && !s.match_prev;
    // Register writes; hardware sets are applied after and win.
    if (wr) begin
      unique case (paddr)
        `GST_OFF_CTRL: begin
          if (pstrb[0]) begin
            d.on = pwdata[`GST_CT_ON];
            d.sbyp = pwdata[`GST_CT_SBYP];
            d.ps = pwdata[`GST_CT_PS_HI:`GST_CT_PS_LO];
            d.cs = gst_clk_src_t'(pwdata[`GST_CT_CS_HI:`GST_CT_CS_LO]);
            d.osc = pwdata[`GST_CT_OSC];
          end
          if (pstrb[1]) begin
            d.cap_en = pwdata[`GST_CT_CAP];
            d.cmp_en = pwdata[`GST_CT_CMP];
            d.acl_en = pwdata[`GST_CT_ACL];
          end
        end
        `GST_OFF_GATE: begin
          if (pstrb[0]) begin
            d.ge = pwdata[`GST_GT_GE];
            d.pol = pwdata[`GST_GT_POL];
            d.tm = pwdata[`GST_GT_TM];
            d.spm = pwdata[`GST_GT_SPM];
            d.gss = gst_gate_src_t'(pwdata[`GST_GT_SS_HI:`GST_GT_SS_LO]);
          end
        end
        `GST_OFF_CAPCMP: begin
          if (pstrb[0]) begin
            d.capcmp[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            d.capcmp[15:8] = pwdata[15:8];
          end
        end
        `GST_OFF_FLAGS: begin
          if (pstrb[0]) begin
            d.ovf = s.ovf && !pwdata[`GST_FL_OVF];
            d.gev = s.gev && !pwdata[`GST_FL_GEV];
          end
        end
        `GST_OFF_IRQEN: begin
          if (pstrb[0]) begin
            d.ovf_ie = pwdata[`GST_IE_OVF];
            d.gev_ie = pwdata[`GST_IE_GEV];
            d.peripheral_irq_enable = pwdata[`GST_IE_PERIPHERAL_IRQ_ENABLE];
            d.global_irq_enable = pwdata[`GST_IE_GIE];
          end
        end
        default: begin
        end
      endcase
    end
    // Software arming wins over the hardware clear in the same cycle.
    if (wr && paddr == `GST_OFF_GATE && pstrb[0]) begin
      d.arm = pwdata[`GST_GT_ARM];
    end else if (s.spm && s.gval && !gsp) begin
      d.arm = 1'b0;
    end
    if (s.cap_en && capture_event) begin
      d.capcmp = s.count;
    end
    if (inc && s.count == `GST_CNT_MAX && !acl) begin
      d.ovf = 1'b1;
    end
    if (s.gval && !gsp) begin
      d.gev = 1'b1;
    end
    d.irq = (s.peripheral_irq_enable && s.global_irq_enable) &&
            ((s.ovf && s.ovf_ie && s.on) || (s.gev && s.gev_ie));
    d.wake = sleep_mode && s.on && s.ovf && s.ovf_ie && s.peripheral_irq_enable;
    d.vec = sleep_mode && s.on && s.ovf && s.ovf_ie && s.peripheral_irq_enable &&
            s.global_irq_enable;
    // Read data is captured in the setup cycle and held through access.
    if (psel && !penable) begin
      d.prdata = `GST_WORD_ZERO;
      unique case (paddr)
        `GST_OFF_CTRL: begin
          d.prdata[`GST_CT_ON] = s.on;
          d.prdata[`GST_CT_SBYP] = s.sbyp;
          d.prdata[`GST_CT_PS_HI:`GST_CT_PS_LO] = s.ps;
          d.prdata[`GST_CT_CS_HI:`GST_CT_CS_LO] = s.cs;
          d.prdata[`GST_CT_OSC] = s.osc;
          d.prdata[`GST_CT_CAP] = s.cap_en;
          d.prdata[`GST_CT_CMP] = s.cmp_en;
          d.prdata[`GST_CT_ACL] = s.acl_en;
        end
        `GST_OFF_GATE: begin
          d.prdata[`GST_GT_GE] = s.ge;
          d.prdata[`GST_GT_POL] = s.pol;
          d.prdata[`GST_GT_TM] = s.tm;
          d.prdata[`GST_GT_SPM] = s.spm;
          d.prdata[`GST_GT_ARM] = s.arm;
          d.prdata[`GST_GT_VAL] = s.gval;
          d.prdata[`GST_GT_SS_HI:`GST_GT_SS_LO] = s.gss;
        end
        `GST_OFF_COUNT: d.prdata[15:0] = s.count;
        `GST_OFF_CAPCMP: d.prdata[15:0] = s.capcmp;
        `GST_OFF_FLAGS: begin
          d.prdata[`GST_FL_OVF] = s.ovf;
          d.prdata[`GST_FL_GEV] = s.gev;
        end
        `GST_OFF_IRQEN: begin
          d.prdata[`GST_IE_OVF] = s.ovf_ie;
          d.prdata[`GST_IE_GEV] = s.gev_ie;
          d.prdata[`GST_IE_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
          d.prdata[`GST_IE_GIE] = s.global_irq_enable;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign prdata = s.prdata;
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign compare_event = s.cmp_evt;
  assign count_value = s.count;
  assign irq_req = s.irq;
  assign wake_req = s.wake;
  assign irq_vector_req = s.vec;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  count_off_hold_a: assert property (
    !s.on && !cnt_wr_lo && !cnt_wr_hi && !acl |=> $stable(s.count))
    else $error("count moved while counter off");
  gate_hold_a: assert property (
    s.on && s.ge && !s.gval && !cnt_wr_lo && !cnt_wr_hi && !acl
    |=> $stable(s.count))
    else $error("count moved while gate closed");
  wrap_flag_a: assert property (
    inc && !acl && !cnt_wr_lo && !cnt_wr_hi && s.count == `GST_CNT_MAX
    |=> s.ovf && s.count == `GST_CNT_ZERO)
    else $error("wrap did not set overflow");
  acl_clear_a: assert property (
    acl && !cnt_wr_lo && !cnt_wr_hi && !s.ovf && !wr
    |=> s.count == `GST_CNT_ZERO && !s.ovf)
    else $error("auto clear wrong");
  write_wins_a: assert property (
    acl && cnt_wr_lo |=> s.count[7:0] == $past(pwdata[7:0]))
    else $error("count write lost to auto clear");
  toggle_clear_a: assert property (
    !s.tm |=> !s.tog)
    else $error("toggle flop not held clear");
  gate_event_a: assert property (
    $fell(s.gval) |-> s.gev)
    else $error("gate fall did not set event flag");
  arm_clear_a: assert property (
    s.spm && !wr ##1 $fell(s.gval) |-> !s.arm)
    else $error("arm not cleared at trailing edge");
  disarm_hold_a: assert property (
    s.spm && !s.arm && !s.sp_run |=> !s.gval)
    else $error("gate opened while disarmed");
  capture_a: assert property (
    s.cap_en && capture_event |=> s.capcmp == $past(s.count))
    else $error("capture missed");
  overflow_irq_a: assert property (
    s.irq |-> $past(s.peripheral_irq_enable && s.global_irq_enable))
    else $error("irq without global enables");
  free_run_a: assert property (
    s.on && !s.ge && pre_done && !acl && !cnt_wr_lo && !cnt_wr_hi
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("free running counter missed a tick");
  prescale_clear_a: assert property (
    cnt_wr_lo || cnt_wr_hi |=> s.pre == `GST_PRE_ZERO)
    else $error("count write left prescaler running");
  sleep_hold_a: assert property (
    sleep_mode && !(s.cs == GST_CS_EXT && s.sbyp) && !acl &&
    !cnt_wr_lo && !cnt_wr_hi |=> $stable(s.count))
    else $error("count moved in sleep");
  flag_clear_a: assert property (
    wr && paddr == `GST_OFF_FLAGS && pstrb[0] && pwdata[`GST_FL_OVF] &&
    !(inc && s.count == `GST_CNT_MAX) |=> !s.ovf)
    else $error("overflow flag not cleared");
  sleep_wake_a: assert property (
    s.wake |-> $past(sleep_mode && s.ovf && s.ovf_ie && s.peripheral_irq_enable))
    else $error("wake without enabled overflow");

  wrap_c: cover property (inc && s.count == `GST_CNT_MAX);
  single_pulse_c: cover property (s.spm && $fell(s.arm));
  toggle_c: cover property (s.tm && $rose(s.tog));
  acl_c: cover property (acl);
  sleep_wake_c: cover property (s.wake);

endmodule

`default_nettype wire

/* pkg/gst_params.svh */
// Purpose: Named offsets, field positions and constants of the gated timer.
// Assumes: Included by its bare name after the package.
// Notes: Definitions only.
`ifndef GST_PARAMS_SVH
`define GST_PARAMS_SVH

`define GST_OFF_CTRL 8'h00
`define GST_OFF_GATE 8'h04
`define GST_OFF_COUNT 8'h08
`define GST_OFF_CAPCMP 8'h0C
`define GST_OFF_FLAGS 8'h10
`define GST_OFF_IRQEN 8'h14

`define GST_CT_ON 0
`define GST_CT_SBYP 1
`define GST_CT_PS_LO 2
`define GST_CT_PS_HI 3
`define GST_CT_CS_LO 4
`define GST_CT_CS_HI 5
`define GST_CT_OSC 6
`define GST_CT_CAP 8
`define GST_CT_CMP 9
`define GST_CT_ACL 10

`define GST_GT_GE 0
`define GST_GT_POL 1
`define GST_GT_TM 2
`define GST_GT_SPM 3
`define GST_GT_ARM 4
`define GST_GT_VAL 5
`define GST_GT_SS_LO 6
`define GST_GT_SS_HI 7

`define GST_FL_OVF 0
`define GST_FL_GEV 1
`define GST_IE_OVF 0
`define GST_IE_GEV 1
`define GST_IE_PERIPHERAL_IRQ_ENABLE 2
`define GST_IE_GIE 3

`define GST_IN_PIN 0
`define GST_IN_CMP1 1
`define GST_IN_CMP2 2
`define GST_IN_EXT 3
`define GST_IN_LFO 4

`define GST_CNT_MAX 16'hFFFF
`define GST_CNT_ZERO 16'h0000
`define GST_WORD_ZERO 32'h0000_0000
`define GST_DIV4_LAST 2'h3
`define GST_PS_M1 3'h0
`define GST_PS_M2 3'h1
`define GST_PS_M4 3'h3
`define GST_PS_M8 3'h7
`define GST_PRE_ZERO 3'h0

`endif

/* pkg/gst_pkg.sv */
// Purpose: Types of the gated timer.
// Assumes: Nothing beyond SystemVerilog.
// Notes: The state struct holds every flip-flop of the core.
package gst_pkg;

  typedef enum logic [1:0] {
    GST_CS_INSTR, GST_CS_SYS, GST_CS_EXT, GST_CS_LFO
  } gst_clk_src_t;

  typedef enum logic [1:0] {
    GST_GS_PIN, GST_GS_AUX, GST_GS_CMP1, GST_GS_CMP2
  } gst_gate_src_t;

  typedef struct packed {
    logic on;
    logic sbyp;
    logic [1:0] ps;
    gst_clk_src_t cs;
    logic osc;
    logic cap_en;
    logic cmp_en;
    logic acl_en;
    logic ge;
    logic pol;
    logic tm;
    logic spm;
    logic arm;
    gst_gate_src_t gss;
    logic [15:0] count;
    logic [15:0] capcmp;
    logic ovf;
    logic gev;
    logic ovf_ie;
    logic gev_ie;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic [1:0] clk_prev;
    logic [1:0] div4;
    logic [2:0] pre;
    logic [1:0] cmp_tb;
    logic gpol_prev;
    logic tog;
    logic gt_prev;
    logic sp_run;
    logic gval;
    logic match_prev;
    logic cmp_evt;
    logic irq;
    logic wake;
    logic vec;
    logic [31:0] prdata;
  } gst_state_t;

endpackage

/* testbench/gst_gate_src.sv */
// Purpose: Far-side model of the gate sources and the count clock.
// Assumes: Commanded from the bench on pclk edges.
// Notes: Unselected sources show the inverse level, so a wrong select shows.
`timescale 1ns/1ps
`default_nettype none

module gst_gate_src (
  // Control
  input wire logic pclk,
  input wire logic lvl,
  input wire logic [1:0] sel,
  // Sources
  output logic pin,
  output logic aux,
  output logic cmp1,
  output logic cmp2,
  output logic ext_clk
);
  logic [2:0] div_q = 3'h0;
  always_comb begin
    pin = (sel == 2'h0) ? lvl : !lvl;
    aux = (sel == 2'h1) ? lvl : !lvl;
    cmp1 = (sel == 2'h2) ? lvl : !lvl;
    cmp2 = (sel == 2'h3) ? lvl : !lvl;
  end
  always @(posedge pclk) begin
    div_q <= div_q + 3'h1;
  end
  assign ext_clk = div_q[2];
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench of the gated timer over APB.
// Assumes: Zero wait-state slave; gate paths settle within ten cycles.
// Notes: Waits after gate changes cover the pin filter latency.
`include "gst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import gst_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic lvl, ext, cap, sleep, cev, irq, err, seen, wake, vec;
  logic [1:0] sel;
  logic [15:0] count_value, c, mx;
  logic p1, p2, p3, p4;
  int bad_count, checks;

  gst_gate_src i_src (.pclk, .lvl, .sel, .pin(p1), .aux(p2),
    .cmp1(p3), .cmp2(p4), .ext_clk(ext));
  gst_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .gate_input_pin(p1), .aux_timer_wrap(p2),
    .comparator_one_gate_out(p3), .comparator_two_gate_out(p4),
    .cmp_one_sync_sel(1'b1), .cmp_two_sync_sel(1'b0),
    .external_count_clock_pin(ext), .low_freq_internal_osc(ext),
    .sleep_mode(sleep), .capture_event(cap), .compare_event(cev),
    .count_value, .irq_req(irq), .wake_req(wake), .irq_vector_req(vec));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Setup, then access held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      chk(32'h0000_0000, 32'h0000_0001);
      test_done();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, `GST_WORD_ZERO);
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, lvl, cap, sleep} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sel = 2'h0;
    tick(20);
    presetn <= 1'b1;
    tick(1);
    rd(`GST_OFF_CTRL);
    chk(rdv, 32'h0000_0000);
    rd(8'h20);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    $display("test reset done");
    wr(`GST_OFF_COUNT, 32'h0000_0000);
    wr(`GST_OFF_CTRL, 32'h0000_0011);
    tick(20);
    chk({31'h0, count_value != 16'h0000}, 32'h0000_0001);
    wr(`GST_OFF_CTRL, 32'h0000_0000);
    c = count_value;
    tick(10);
    chk({16'h0, count_value}, {16'h0, c});
    for (int p = 0; p < 4; p++) begin
      wr(`GST_OFF_CTRL, 32'h0000_0011 | (p << 2));
      wr(`GST_OFF_COUNT, 32'h0000_0000);
      c = count_value;
      tick(64);
      mx = count_value - c - 16'(64 >> p);
      chk({31'h0, mx + 16'h0002 <= 16'h0004}, 32'h0000_0001);
    end
    $display("test free run done");
    wr(`GST_OFF_IRQEN, 32'h0000_000D);
    wr(`GST_OFF_COUNT, 32'h0000_FFF0);
    wr(`GST_OFF_CTRL, 32'h0000_0011);
    tick(30);
    rd(`GST_OFF_FLAGS);
    chk(rdv & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, count_value < 16'h0040}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`GST_OFF_FLAGS, 32'h0000_0001);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test overflow done");
    wr(`GST_OFF_IRQEN, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      sel <= 2'(s);
      lvl <= 1'b1;
      wr(`GST_OFF_GATE, 32'h0000_0001 | (s << 6));
      tick(10);
      c = count_value;
      tick(10);
      chk({16'h0, count_value}, {16'h0, c});
      lvl <= 1'b0;
      wr(`GST_OFF_GATE, 32'h0000_0003 | (s << 6));
      tick(10);
      c = count_value;
      tick(10);
      chk({16'h0, count_value}, {16'h0, c});
      lvl <= 1'b1;
      tick(10);
      chk({31'h0, count_value != c}, 32'h0000_0001);
    end
    $display("test gate sources done");
    sel <= 2'h0;
    wr(`GST_OFF_GATE, 32'h0000_0002);
    tick(10);
    wr(`GST_OFF_FLAGS, 32'h0000_0003);
    wr(`GST_OFF_IRQEN, 32'h0000_000E);
    rd(`GST_OFF_GATE);
    chk({31'h0, rdv[5]}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    lvl <= 1'b0;
    tick(10);
    rd(`GST_OFF_GATE);
    chk({31'h0, rdv[5]}, 32'h0000_0000);
    rd(`GST_OFF_FLAGS);
    chk(rdv & 32'h0000_0002, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`GST_OFF_FLAGS, 32'h0000_0003);
    wr(`GST_OFF_IRQEN, 32'h0000_0000);
    $display("test gate event done");
    wr(`GST_OFF_GATE, 32'h0000_000B);
    wr(`GST_OFF_COUNT, 32'h0000_0000);
    wr(`GST_OFF_GATE, 32'h0000_001B);
    tick(10);
    chk({16'h0, count_value}, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      lvl <= 1'b1;
      tick(20);
      lvl <= 1'b0;
      tick(10);
      if (k == 0) c = count_value;
    end
    chk({31'h0, c != 16'h0000}, 32'h0000_0001);
    chk({16'h0, count_value}, {16'h0, c});
    rd(`GST_OFF_GATE);
    chk({31'h0, rdv[4]}, 32'h0000_0000);
    wr(`GST_OFF_GATE, 32'h0000_0003);
    wr(`GST_OFF_COUNT, 32'h0000_0000);
    wr(`GST_OFF_GATE, 32'h0000_000F);
    wr(`GST_OFF_GATE, 32'h0000_001F);
    lvl <= 1'b1;
    tick(20);
    c = count_value;
    lvl <= 1'b0;
    tick(20);
    chk({31'h0, count_value > c}, 32'h0000_0001);
    lvl <= 1'b1;
    tick(20);
    lvl <= 1'b0;
    tick(10);
    c = count_value;
    lvl <= 1'b1;
    tick(20);
    chk({16'h0, count_value}, {16'h0, c});
    wr(`GST_OFF_GATE, 32'h0000_0003);
    wr(`GST_OFF_GATE, 32'h0000_0007);
    tick(10);
    c = count_value;
    tick(10);
    chk({16'h0, count_value}, {16'h0, c});
    $display("test pulse modes done");
    wr(`GST_OFF_GATE, 32'h0000_0000);
    wr(`GST_OFF_CTRL, 32'h0000_0100);
    wr(`GST_OFF_COUNT, 32'h0000_1234);
    cap <= 1'b1;
    tick(1);
    cap <= 1'b0;
    tick(2);
    rd(`GST_OFF_CAPCMP);
    chk(rdv, 32'h0000_1234);
    wr(`GST_OFF_FLAGS, 32'h0000_0003);
    wr(`GST_OFF_CAPCMP, 32'h0000_0020);
    wr(`GST_OFF_COUNT, 32'h0000_0000);
    wr(`GST_OFF_CTRL, 32'h0000_0611);
    mx = 16'h0000;
    seen = 1'b0;
    for (int i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (count_value > mx) mx = count_value;
      if (cev === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0000_0001);
    chk({31'h0, mx < 16'h0028}, 32'h0000_0001);
    rd(`GST_OFF_FLAGS);
    chk(rdv & 32'h0000_0001, 32'h0000_0000);
    wr(`GST_OFF_COUNT, 32'h0000_1000);
    wr(`GST_OFF_COUNT, 32'h0000_001F);
    wr(`GST_OFF_COUNT, 32'h0000_0055);
    chk({31'h0, count_value - 16'h0055 < 16'h0004}, 32'h0000_0001);
    $display("test capture compare done");
    sleep <= 1'b1;
    wr(`GST_OFF_CTRL, 32'h0000_0011);
    c = count_value;
    tick(20);
    chk({16'h0, count_value}, {16'h0, c});
    wr(`GST_OFF_CTRL, 32'h0000_0023);
    tick(60);
    chk({31'h0, count_value != c}, 32'h0000_0001);
    wr(`GST_OFF_IRQEN, 32'h0000_0005);
    wr(`GST_OFF_COUNT, 32'h0000_FFFE);
    tick(40);
    chk({30'h0, wake, vec}, 32'h0000_0002);
    wr(`GST_OFF_IRQEN, 32'h0000_000D);
    tick(2);
    chk({30'h0, wake, vec}, 32'h0000_0003);
    $display("test sleep done");
    test_done();
  end
endmodule

`default_nettype wire
